/* msbc_defines.svh */
// offsets, field positions, reset values and timing counts of the sideband control block
// assumes a single 250 MHz core clock; included by msbc_pkg.sv and msbc_top.sv
`ifndef MSBC_DEFINES_SVH
`define MSBC_DEFINES_SVH

// timing
`define MSBC_CLK_PERIOD_NS 4
`define MSBC_RESET_MIN_NS  1000

// lane layout
`define MSBC_LANES   4
`define MSBC_LEVEL_W 16

// 2-wire device address (7 bits)
`define MSBC_DEV_ADDR 7'h50

// apb byte addresses
`define MSBC_APB_STATUS 12'h000
`define MSBC_APB_MASK   12'h004
`define MSBC_APB_THRESH 12'h008
`define MSBC_APB_STATE  12'h00c
`define MSBC_APB_LVL01  12'h010
`define MSBC_APB_LVL23  12'h014

// 2-wire memory map byte offsets
`define MSBC_MAP_STATUS 8'h00
`define MSBC_MAP_LOS    8'h01
`define MSBC_MAP_LVL_LO 8'h02
`define MSBC_MAP_LVL_HI 8'h09
`define MSBC_MAP_TXDIS  8'h0a
`define MSBC_MAP_FLAGS  8'h0b

// reset values
`define MSBC_MASK_RST   5'h1f
`define MSBC_THRESH_RST 16'h0100
`define MSBC_TXDIS_RST  4'h0
`define MSBC_PIN_IDLE   6'h33

`endif

/* msbc_pkg.sv */
// types shared by the sideband control block
// assumes msbc_defines.svh is on the include path
`include "msbc_defines.svh"
package msbc_pkg;

	// module reset sequencer, gray along boot-run-low-hold-boot
	typedef enum logic [1:0] {
		INIT_BOOT = 2'b00,
		INIT_RUN  = 2'b01,
		INIT_LOW  = 2'b11,
		INIT_HOLD = 2'b10
	} msbc_init_type;

	// 2-wire slave byte phase
	typedef enum logic [2:0] {
		TW_IDLE = 3'b000,
		TW_ADDR = 3'b001,
		TW_PTR  = 3'b011,
		TW_WR   = 3'b010,
		TW_RD   = 3'b110
	} msbc_tw_type;

	// sticky event flags, same layout for status and mask
	typedef struct packed {
		logic [`MSBC_LANES-1:0] los;
		logic                   reset_done;
	} msbc_event_type;

endpackage

/* msbc_top.sv */
// sideband control and status logic of a pluggable four-lane optical module
// assumes pins arrive asynchronously, lane levels come from a monitor on clk_i
`timescale 1ns/1ns
`include "msbc_defines.svh"

module msbc_top #(
	parameter int         RESET_MIN_CYCLES = (`MSBC_RESET_MIN_NS + `MSBC_CLK_PERIOD_NS - 1)
	                                         / `MSBC_CLK_PERIOD_NS,
	parameter logic [6:0] DEV_ADDR         = `MSBC_DEV_ADDR
) (
	input  wire logic                     clk_i,                // core clock
	input  wire logic                     rst_b_i,              // sync reset, low
	input  wire logic                     psel_i,               // apb select
	input  wire logic                     penable_i,            // apb enable
	input  wire logic                     pwrite_i,             // apb direction
	input  wire logic [11:0]              paddr_i,              // apb byte address
	input  wire logic [31:0]              pwdata_i,             // apb write data
	output logic      [31:0]              prdata_o,             // apb read data
	output logic                          pready_o,             // apb ready
	output logic                          pslverr_o,            // apb error
	input  wire logic                     module_select_n_i,    // select pin, low
	input  wire logic                     module_reset_n_i,     // reset pin, low
	input  wire logic                     low_power_select_i,   // low power pin
	input  wire logic                     transmit_disable_i,   // tx disable pin
	input  wire logic                     scl_i,                // 2-wire clock in
	input  wire logic                     sda_i,                // 2-wire data in
	output logic                          sda_o,                // 2-wire data out
	output logic                          sda_oe_n_o,           // data enable, low
	input  wire logic [`MSBC_LANES*`MSBC_LEVEL_W-1:0] rx_level_i, // lane levels
	output logic                          module_present_n_o,   // presence, low
	output logic                          interrupt_out_n_o,    // interrupt value
	output logic                          interrupt_oe_n_o,     // interrupt enable, low
	output logic                          irq_o,                // interrupt, high
	output logic                          receive_signal_lost_o, // los alarm
	output logic      [`MSBC_LANES-1:0]   tx_off_o,             // per-lane tx off
	output logic                          power_limit_o         // power limit
);

	localparam int RCW = $clog2(RESET_MIN_CYCLES + 1);
	localparam int LW  = `MSBC_LANES * `MSBC_LEVEL_W;

	// level compare per lane
	function automatic logic [`MSBC_LANES-1:0] msbc_below(input logic [LW-1:0] lv,
	                                                     input logic [15:0] thr);
		logic [`MSBC_LANES-1:0] r;
		r = '0;
		for (int k = 0; k < `MSBC_LANES; k++) begin
			r[k] = lv[k*16 +: 16] < thr;
		end
		return r;
	endfunction

	// byte of the 2-wire memory map
	function automatic logic [7:0] msbc_map_byte(input logic [7:0] a,
	                                            input logic [7:0] st,
	                                            input logic [3:0] los,
	                                            input logic [LW-1:0] lv,
	                                            input logic [3:0] txd,
	                                            input logic [4:0] flg);
		logic [7:0] b;
		logic [7:0] r;
		b = a - `MSBC_MAP_LVL_LO;
		r = 8'h00;
		if (a == `MSBC_MAP_STATUS) begin
			r = st;
		end else if (a == `MSBC_MAP_LOS) begin
			r = {4'h0, los};
		end else if (a >= `MSBC_MAP_LVL_LO && a <= `MSBC_MAP_LVL_HI) begin
			r = lv[{b[2:1], ~b[0], 3'h0} +: 8];
		end else if (a == `MSBC_MAP_TXDIS) begin
			r = {4'h0, txd};
		end else if (a == `MSBC_MAP_FLAGS) begin
			r = {3'h0, flg};
		end
		return r;
	endfunction

	logic [5:0]              pin_meta_q;
	logic [5:0]              pin_sync_q;
	logic                    scl_p_q;
	logic                    sda_p_q;
	msbc_pkg::msbc_init_type init_q;
	msbc_pkg::msbc_init_type init_d;
	logic [RCW-1:0]          rcnt_q;
	logic [4:0]              mask_q;
	logic [15:0]             thresh_q;
	logic [3:0]              txdis_sw_q;
	msbc_pkg::msbc_event_type status_q;
	msbc_pkg::msbc_event_type status_d;
	logic [LW-1:0]           level_q;
	logic [3:0]              los_q;
	logic                    irq_q;
	logic                    pready_q;
	logic                    pslverr_q;
	logic [31:0]             prdata_q;
	logic                    lp_q;
	msbc_pkg::msbc_tw_type   tw_q;
	logic [3:0]              bit_cnt_q;
	logic [7:0]              rx_q;
	logic [7:0]              tx_q;
	logic [7:0]              ptr_q;
	logic                    drive_q;

	// synchronised pins: select, reset, low power, disable, scl, sda
	wire logic [5:0] pin_raw = {sda_i, scl_i, transmit_disable_i, low_power_select_i,
	                            module_reset_n_i, module_select_n_i};
	wire logic sel_n  = pin_sync_q[0];
	wire logic mrst_n = pin_sync_q[1];
	wire logic lp     = pin_sync_q[2];
	wire logic txd    = pin_sync_q[3];
	wire logic scl    = pin_sync_q[4];
	wire logic sda    = pin_sync_q[5];

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pin_meta_q <= `MSBC_PIN_IDLE;
			pin_sync_q <= `MSBC_PIN_IDLE;
			scl_p_q    <= 1'b1;
			sda_p_q    <= 1'b1;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
			scl_p_q    <= scl;
			sda_p_q    <= sda;
		end
	end

	// reset sequencer state and completion
	// the counter starts one sample after the first low one, so a pulse must stand
	// more than RESET_MIN_CYCLES synced samples before the settings are cleared
	wire logic rcnt_full = rcnt_q == RCW'(RESET_MIN_CYCLES - 1);
	wire logic soft_clr  = init_q == msbc_pkg::INIT_HOLD;
	wire logic not_ready = init_q == msbc_pkg::INIT_BOOT || soft_clr;
	wire logic done_evt  = init_q == msbc_pkg::INIT_BOOT;

	always_comb begin
		init_d = init_q;
		unique case (init_q)
			msbc_pkg::INIT_BOOT: init_d = msbc_pkg::INIT_RUN;
			msbc_pkg::INIT_RUN:  if (!mrst_n) init_d = msbc_pkg::INIT_LOW;
			msbc_pkg::INIT_LOW: begin
				if (mrst_n) begin
					init_d = msbc_pkg::INIT_RUN;
				end else if (rcnt_full) begin
					init_d = msbc_pkg::INIT_HOLD;
				end
			end
			msbc_pkg::INIT_HOLD: if (mrst_n) init_d = msbc_pkg::INIT_BOOT;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			init_q <= msbc_pkg::INIT_BOOT;
			rcnt_q <= '0;
		end else begin
			init_q <= init_d;
			rcnt_q <= (init_q == msbc_pkg::INIT_LOW) ? rcnt_q + RCW'(1) : '0;
		end
	end

	// apb decode, one wait state per access
	// unmapped addresses answer with an error and change nothing
	wire logic apb_acc    = psel_i & penable_i;
	wire logic apb_fire   = apb_acc & pready_q;
	wire logic apb_wr     = apb_fire & pwrite_i;
	wire logic hit_status = paddr_i == `MSBC_APB_STATUS;
	wire logic hit_mask   = paddr_i == `MSBC_APB_MASK;
	wire logic hit_thresh = paddr_i == `MSBC_APB_THRESH;
	wire logic hit_state  = paddr_i == `MSBC_APB_STATE;
	wire logic hit_lvl01  = paddr_i == `MSBC_APB_LVL01;
	wire logic hit_lvl23  = paddr_i == `MSBC_APB_LVL23;
	wire logic mapped     = hit_status | hit_mask | hit_thresh | hit_state | hit_lvl01 | hit_lvl23;
	wire logic [10:0] state_bits = {tx_off_o, lp_q, ~sel_n, los_q, not_ready};
	wire logic [31:0] apb_rdata =
		hit_status ? {27'h0, status_q} :
		hit_mask   ? {27'h0, mask_q} :
		hit_thresh ? {16'h0, thresh_q} :
		hit_state  ? {21'h0, state_bits} :
		hit_lvl01  ? level_q[31:0] :
		hit_lvl23  ? level_q[63:32] : 32'h0;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= apb_acc & ~pready_q;
			pslverr_q <= apb_acc & ~pready_q & ~mapped;
			prdata_q  <= (apb_acc & ~pready_q & ~pwrite_i) ? apb_rdata : 32'h0;
		end
	end

	// 2-wire line events
	// every event lags the pins by the two synchroniser stages
	wire logic tw_abort  = sel_n | soft_clr;
	wire logic scl_rise  = scl & ~scl_p_q;
	wire logic scl_fall  = ~scl & scl_p_q;
	wire logic tw_start  = scl & scl_p_q & sda_p_q & ~sda;
	wire logic tw_stop   = scl & scl_p_q & ~sda_p_q & sda;
	wire logic tw_active = tw_q != msbc_pkg::TW_IDLE;
	wire logic byte_done = scl_fall & tw_active & (bit_cnt_q == 4'h8);
	wire logic tw_we     = byte_done & (tw_q == msbc_pkg::TW_WR);
	wire logic [7:0] map_st = {6'h0, irq_q, not_ready};
	wire logic [7:0] map_rd = msbc_map_byte(ptr_q, map_st, los_q, level_q, txdis_sw_q,
	                                        status_q);

	// 2-wire slave: address, pointer, write and read bytes
	// a read loads its next byte at the ninth falling edge and moves the pointer on
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || tw_abort) begin
			tw_q      <= msbc_pkg::TW_IDLE;
			bit_cnt_q <= 4'h0;
			drive_q   <= 1'b0;
			rx_q      <= 8'h00;
			tx_q      <= 8'h00;
			ptr_q     <= 8'h00;
		end else if (tw_start) begin
			tw_q      <= msbc_pkg::TW_ADDR;
			bit_cnt_q <= 4'h0;
			drive_q   <= 1'b0;
		end else if (tw_stop) begin
			tw_q    <= msbc_pkg::TW_IDLE;
			drive_q <= 1'b0;
		end else if (scl_rise && tw_active) begin
			if (bit_cnt_q < 4'h8) begin
				if (tw_q != msbc_pkg::TW_RD) rx_q <= {rx_q[6:0], sda};
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end else begin
				bit_cnt_q <= 4'h9;
				if (tw_q == msbc_pkg::TW_RD && sda) tw_q <= msbc_pkg::TW_IDLE;
			end
		end else if (byte_done) begin
			unique case (tw_q)
				msbc_pkg::TW_ADDR: begin
					drive_q <= rx_q[7:1] == DEV_ADDR;
					if (rx_q[7:1] != DEV_ADDR) tw_q <= msbc_pkg::TW_IDLE;
					else tw_q <= rx_q[0] ? msbc_pkg::TW_RD : msbc_pkg::TW_PTR;
				end
				msbc_pkg::TW_PTR: begin
					ptr_q   <= rx_q;
					drive_q <= 1'b1;
					tw_q    <= msbc_pkg::TW_WR;
				end
				msbc_pkg::TW_WR: begin
					ptr_q   <= ptr_q + 8'h01;
					drive_q <= 1'b1;
				end
				default: drive_q <= 1'b0;                                  // master acks
			endcase
		end else if (scl_fall && tw_active && bit_cnt_q == 4'h9) begin
			bit_cnt_q <= 4'h0;
			if (tw_q == msbc_pkg::TW_RD) begin
				drive_q <= ~map_rd[7];
				tx_q    <= {map_rd[6:0], 1'b0};
				ptr_q   <= ptr_q + 8'h01;
			end else begin
				drive_q <= 1'b0;
			end
		end else if (scl_fall && tw_q == msbc_pkg::TW_RD && bit_cnt_q != 4'h0) begin
			drive_q <= ~tx_q[7];
			tx_q    <= {tx_q[6:0], 1'b0};
		end
	end

	// events, set wins over clear from either side
	// loss events are rising edges only, a lane that stays low raises one event
	wire logic [3:0] los_d = msbc_below(level_q, thresh_q);
	wire logic [4:0] apb_clr = (apb_wr && hit_status) ? pwdata_i[4:0] : 5'h0;
	wire logic [4:0] tw_clr  = (tw_we && ptr_q == `MSBC_MAP_FLAGS) ? rx_q[4:0] : 5'h0;
	wire msbc_pkg::msbc_event_type evt = '{los: los_d & ~los_q, reset_done: done_evt};

	always_comb begin
		status_d = (status_q & ~(apb_clr | tw_clr)) | evt;
	end

	// settings, returned to defaults during a module reset
	// apb and 2-wire writes meet only at the status flags, which both can clear
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || soft_clr) begin
			mask_q     <= `MSBC_MASK_RST;
			thresh_q   <= `MSBC_THRESH_RST;
			txdis_sw_q <= `MSBC_TXDIS_RST;
			status_q   <= '0;
		end else begin
			status_q <= status_d;
			if (apb_wr && hit_mask) mask_q <= pwdata_i[4:0];
			if (apb_wr && hit_thresh) thresh_q <= pwdata_i[15:0];
			if (tw_we && ptr_q == `MSBC_MAP_TXDIS) txdis_sw_q <= rx_q[3:0];
		end
	end

	// lane monitor, alarm, interrupt and power level
	// levels reset to full scale, else the first compare raises false loss events
	// no interrupt while a module reset holds the settings at their defaults
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			level_q <= '1;
			los_q   <= 4'h0;
			irq_q   <= 1'b0;
			lp_q    <= 1'b0;
		end else begin
			level_q <= rx_level_i;
			los_q   <= los_d;
			irq_q   <= ~soft_clr & (|(status_d & mask_q));
			lp_q    <= lp;
		end
	end

	// pin and bus outputs
	// presence and interrupt values are constant, only the enables move
	assign prdata_o              = prdata_q;
	assign pready_o              = pready_q;
	assign pslverr_o             = pslverr_q;
	assign sda_o                 = 1'b0;
	assign sda_oe_n_o            = ~drive_q;
	assign module_present_n_o    = 1'b0;
	assign interrupt_out_n_o     = 1'b0;
	assign interrupt_oe_n_o      = ~irq_q;
	assign irq_o                 = irq_q;
	assign receive_signal_lost_o = |los_q;
	assign tx_off_o              = {`MSBC_LANES{txd}} | txdis_sw_q;
	assign power_limit_o         = lp_q;

endmodule

/* msbc_monitor.sv */
// checker of the sideband control block, bound to msbc_top
// assumes one clk_i domain and a synchronous low reset
`timescale 1ns/1ns
module msbc_monitor #(
	parameter int RESET_MIN_CYCLES = 4
) (
	input wire logic        clk_i,                 // core clock
	input wire logic        rst_b_i,               // sync reset, low
	input wire logic        module_select_n_i,     // select pin
	input wire logic        module_reset_n_i,      // reset pin
	input wire logic        low_power_select_i,    // low power pin
	input wire logic        transmit_disable_i,    // tx disable pin
	input wire logic [63:0] rx_level_i,            // lane levels
	input wire logic        sda_oe_n_o,            // data enable, low
	input wire logic        module_present_n_o,    // presence
	input wire logic        interrupt_out_n_o,     // interrupt value
	input wire logic        interrupt_oe_n_o,      // interrupt enable
	input wire logic        irq_o,                 // interrupt level
	input wire logic        receive_signal_lost_o, // los alarm
	input wire logic [3:0]  tx_off_o,              // tx off
	input wire logic        power_limit_o          // power limit
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	logic [15:0] hold_q;
	// counts cycles of a held module reset with the pin disable off
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || module_reset_n_i || transmit_disable_i)
			hold_q <= 16'h0000;
		else if (hold_q != 16'hffff)
			hold_q <= hold_q + 16'h0001;
	end
	property p_present; module_present_n_o == 1'b0; endproperty
	property p_irq_pin; irq_o == !interrupt_oe_n_o && interrupt_out_n_o == 1'b0; endproperty
	property p_boot; $rose(rst_b_i) |-> ##[0:5] irq_o; endproperty
	property p_sel; module_select_n_i [*5] |-> sda_oe_n_o; endproperty
	property p_txdis; transmit_disable_i [*4] |-> tx_off_o == 4'hf; endproperty
	property p_lpw; $stable(low_power_select_i) [*5] |-> power_limit_o == low_power_select_i;
	endproperty
	property p_los; (&rx_level_i) [*3] |-> !receive_signal_lost_o; endproperty
	property p_hold; hold_q >= RESET_MIN_CYCLES + 5 |-> tx_off_o == 4'h0 && !irq_o; endproperty
	a_present: assert property (p_present)
		else $error("presence output not low");
	a_irq_pin: assert property (p_irq_pin)
		else $error("interrupt pin disagrees with irq");
	a_boot: assert property (p_boot)
		else $error("no completion interrupt after power up");
	a_sel: assert property (p_sel)
		else $error("data line driven while deselected");
	a_txdis: assert property (p_txdis)
		else $error("disable pin did not turn lanes off");
	a_lpw: assert property (p_lpw)
		else $error("power limit not following pin");
	a_los: assert property (p_los)
		else $error("los alarm with all lanes at full level");
	a_hold: assert property (p_hold)
		else $error("settings not at default during reset");
	c_irq: cover property ($rose(irq_o));
	c_ack: cover property (!sda_oe_n_o);
	c_los: cover property ($rose(receive_signal_lost_o));
endmodule
bind msbc_top msbc_monitor #(.RESET_MIN_CYCLES(RESET_MIN_CYCLES)) u_mon (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .module_select_n_i(module_select_n_i),
	.module_reset_n_i(module_reset_n_i), .low_power_select_i(low_power_select_i),
	.transmit_disable_i(transmit_disable_i), .rx_level_i(rx_level_i), .sda_oe_n_o(sda_oe_n_o),
	.module_present_n_o(module_present_n_o), .interrupt_out_n_o(interrupt_out_n_o),
	.interrupt_oe_n_o(interrupt_oe_n_o), .irq_o(irq_o),
	.receive_signal_lost_o(receive_signal_lost_o), .tx_off_o(tx_off_o),
	.power_limit_o(power_limit_o));

/* msbc_host_model.sv */
// host board controller: 2-wire bus master with open-drain data
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ns
module msbc_host_model (
	input  wire logic clk_i,    // core clock
	input  wire logic sda_i,    // resolved data line
	output logic      scl_o,    // bus clock, idle high
	output logic      sda_low_o // pulls data low
);
	// bus clock stands high outside frames
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one bit of 16 core cycles, sampled mid high phase
	task automatic bit_io(input logic b, output logic s);
		sda_low_o <= ~b;
		tick(4);
		scl_o <= 1'b1;
		tick(4);
		s = sda_i;
		tick(4);
		scl_o <= 1'b0;
		tick(4);
	endtask
	// byte then ninth bit, m high releases the line
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(m, s);
		ack = ~s;
	endtask
	// start, also usable as repeated start
	task automatic start();
		sda_low_o <= 1'b0;
		scl_o <= 1'b1;
		tick(8);
		sda_low_o <= 1'b1;
		tick(8);
		scl_o <= 1'b0;
		tick(4);
	endtask
	task automatic stop();
		sda_low_o <= 1'b1;
		tick(4);
		scl_o <= 1'b1;
		tick(8);
		sda_low_o <= 1'b0;
		tick(8);
	endtask
endmodule

/* tb_top.sv */
// self-checking bench of the sideband control block
// assumes msbc_top, its package and the host model are compiled first
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	localparam int RMIN = 4;
	logic        clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, seed, r;
	logic        sel_n, mrst_n, lpm, txdis, scl, sda_low, sda_o, sda_oe_n, e, ok;
	logic        pres_n, int_n, int_oe_n, irq, los, plim;
	logic [3:0]  tx_off;
	logic [7:0]  b;
	logic [63:0] lv, t;
	int          fails, tests_run;
	wire logic   sda_w = !(sda_low || !sda_oe_n); // pull-up
	always #2 clk_i = ~clk_i;
	msbc_top #(.RESET_MIN_CYCLES(RMIN)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.module_select_n_i(sel_n), .module_reset_n_i(mrst_n), .low_power_select_i(lpm),
		.transmit_disable_i(txdis), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n), .rx_level_i(lv), .module_present_n_o(pres_n),
		.interrupt_out_n_o(int_n), .interrupt_oe_n_o(int_oe_n), .irq_o(irq),
		.receive_signal_lost_o(los), .tx_off_o(tx_off), .power_limit_o(plim));
	msbc_host_model host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic los_exp(input logic [63:0] v, input logic [15:0] th);
		for (int k = 0; k < 4; k++)
			if (v[16*k+:16] < th)
				return 1'b1;
		return 1'b0;
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// apb transfer: setup, access until pready sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			conclude();
		end
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i); // idle cycle, next setup never lands on this release
	endtask
	// 2-wire write of one map byte
	task automatic tw_wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		logic a0, a1, a2;
		host.start();
		host.xfer(8'ha0, 1'b1, q, a0);
		host.xfer(p, 1'b1, q, a1);
		host.xfer(d, 1'b1, q, a2);
		host.stop();
		ok = a0 & a1 & a2;
	endtask
	// 2-wire read of one map byte, host ends with nack
	task automatic tw_rd(input logic [7:0] p);
		logic a0, a1, a2, x;
		logic [7:0] q;
		host.start();
		host.xfer(8'ha0, 1'b1, q, a0);
		host.xfer(p, 1'b1, q, a1);
		host.start();
		host.xfer(8'ha1, 1'b1, q, a2);
		host.xfer(8'hff, 1'b1, b, x);
		host.stop();
		ok = a0 & a1 & a2;
	endtask
	initial begin
		clk_i = 0; rst_b_i = 0; psel_i = 0; penable_i = 0; pwrite_i = 0; paddr_i = 0;
		pwdata_i = 0; sel_n = 1; mrst_n = 1; lpm = 0; txdis = 0; lv = '1;
		fails = 0; tests_run = 0; seed = 32'h977b867a;
		cyc(5);
		rst_b_i <= 1'b1;
		cyc(6);
		`CHK("present", 1'b0, pres_n)
		`CHK("boot irq", 1'b1, irq)
		`CHK("int pins", 3'b000, {sda_o, int_n, int_oe_n})
		apb(1'b0, 12'h00c, 0);
		`CHK("not ready", 1'b0, r[0])
		apb(1'b0, 12'h000, 0);
		`CHK("source", 1'b1, r[0])
		apb(1'b0, 12'h004, 0);
		`CHK("mask", 32'h1f, r)
		apb(1'b0, 12'h018, 0);
		`CHK("unmapped", 1'b1, e)
		apb(1'b1, 12'h004, 0);
		cyc(3);
		`CHK("masked", 1'b0, irq)
		apb(1'b1, 12'h004, 32'h1f);
		cyc(3);
		`CHK("unmasked", 1'b1, irq)
		apb(1'b1, 12'h000, 32'h1f);
		cyc(3);
		`CHK("cleared", 1'b0, irq)
		// threshold boundary first, then random lane levels
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			t = {seed[31:17], 1'b0, seed[23:8], seed[15:1], 1'b1, seed[11:0], 4'h0};
			if (i < 2)
				t = {48'hffff_ffff_ffff, i ? 16'h00ff : 16'h0100};
			lv <= t;
			cyc(4);
			`CHK("los", los_exp(t, 16'h0100), los)
		end
		apb(1'b0, 12'h010, 0);
		`CHK("lanes 0 1", t[31:0], r)
		txdis <= 1'b1;
		cyc(4);
		`CHK("pin off", 4'hf, tx_off)
		txdis <= 1'b0;
		sel_n <= 1'b0; // own select line
		cyc(4);
		tw_wr(8'h0a, 8'h05);
		cyc(4);
		`CHK("ack", 1'b1, ok)
		`CHK("map off", 4'h5, tx_off)
		tw_rd(8'h02);
		`CHK("level byte", {1'b1, t[15:8]}, {ok, b})
		`CHK("los source", 1'b1, irq)
		tw_wr(8'h0b, 8'h1f);
		cyc(4);
		`CHK("flags cleared", 1'b0, irq)
		`CHK("flag ack", 1'b1, ok)
		sel_n <= 1'b1;
		cyc(4);
		tw_wr(8'h0a, 8'h0a);
		`CHK("no ack", 1'b0, ok)
		`CHK("kept", 4'h5, tx_off)
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			lpm <= seed[0];
			cyc(5);
			`CHK("power", seed[0], plim)
		end
		apb(1'b1, 12'h008, 32'h200);
		mrst_n <= 1'b0;
		cyc(RMIN - 1);
		mrst_n <= 1'b1;
		cyc(8);
		`CHK("short pulse", 4'h5, tx_off)
		mrst_n <= 1'b0;
		cyc(RMIN + 8);
		mrst_n <= 1'b1;
		cyc(8);
		`CHK("tx default", 4'h0, tx_off)
		`CHK("done irq", 1'b1, irq)
		apb(1'b0, 12'h008, 0);
		`CHK("thresh", 32'h100, r)
		apb(1'b0, 12'h00c, 0);
		`CHK("ready", 1'b0, r[0])
		conclude();
	end
endmodule
